// ==== rcrb_host_model.sv ====
`timescale 1ns/1ps
module rcrb_host_model (
    input wire logic clk_in,
    input wire logic rsp_valid_in,
    input wire logic [15:0] rsp_data_in,
    input wire logic rsp_error_in,
    output logic cmd_valid_out,
    output logic [1:0] cmd_op_out,
    output logic [5:0] cmd_addr_out,
    output logic [15:0] cmd_data_out
);
    // ----------------------------------------
    // command issue
    // ----------------------------------------
    // set by the bench: a write of the same index and data goes one edge ahead
    bit lead_write = 1'b0;

    initial
    begin
        cmd_valid_out = 1'b0;
        cmd_op_out = 2'h0;
        cmd_addr_out = 6'h3F;
        cmd_data_out = 16'hA5A5;
    end

    // one command, then wait a bounded time for its single answer word
    task automatic send(input logic [1:0] op, input logic [5:0] addr, input logic [15:0] data,
                        output logic [15:0] rd, output logic err, output bit ok);
        int n;
        ok = 1'b0;
        rd = 16'h0000;
        err = 1'b1;
        @(posedge clk_in);
        if (lead_write)
        begin
            cmd_valid_out <= 1'b1;
            cmd_op_out <= rcrb_pkg::RCRB_OP_WRITE;
            cmd_addr_out <= addr;
            cmd_data_out <= data;
            @(posedge clk_in);
        end
        cmd_valid_out <= 1'b1;
        cmd_op_out <= op;
        cmd_addr_out <= addr;
        cmd_data_out <= data;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        // released address and data lines are inverted so a stale value cannot pass for a live one; the op line keeps its value
        cmd_addr_out <= ~addr;
        cmd_data_out <= ~data;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (rsp_valid_in === 1'b1)
            begin
                ok = 1'b1;
                rd = rsp_data_in;
                err = rsp_error_in;
            end
            else
                @(posedge clk_in);
        end
    endtask : send
endmodule : rcrb_host_model

// ==== rcrb_pkg.sv ====
package rcrb_pkg;

    // ----------------------------------------
    // command port
    // ----------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 6;
    localparam int NUM_CH = 18;

    typedef enum logic [1:0]
    {
        RCRB_OP_READ  = 2'b00,
        RCRB_OP_WRITE = 2'b01,
        RCRB_OP_RESET = 2'b10
    } rcrb_op_t;

    // ----------------------------------------
    // register indices
    // ----------------------------------------
    localparam logic [5:0] IDX_REJ_DLY   = 6'h00;
    localparam logic [5:0] IDX_BIAS_LVL  = 6'h01;
    localparam logic [5:0] IDX_ANOM_LVL  = 6'h02;
    localparam logic [5:0] IDX_SHAPER    = 6'h03;
    localparam logic [5:0] IDX_REJ_WID   = 6'h04;
    localparam logic [5:0] IDX_HIT_WID   = 6'h05;
    localparam logic [5:0] IDX_HIT_DEAD  = 6'h06;
    localparam logic [5:0] IDX_HIT_DLY   = 6'h07;
    localparam logic [5:0] IDX_PH_EN_LO  = 6'h08;
    localparam logic [5:0] IDX_PH_EN_HI  = 6'h09;
    localparam logic [5:0] IDX_REJ_EN_LO = 6'h0A;
    localparam logic [5:0] IDX_REJ_EN_HI = 6'h0B;
    localparam logic [5:0] IDX_PH_MAX    = 6'h0C;
    localparam logic [5:0] IDX_MODE      = 6'h0D;
    localparam logic [5:0] IDX_STATUS    = 6'h0E;
    localparam logic [5:0] IDX_LAST_CMD  = 6'h0F;
    localparam logic [5:0] IDX_DIAG      = 6'h10;
    localparam logic [5:0] IDX_REJ_CNT   = 6'h11;
    localparam logic [5:0] IDX_BOARD_ID  = 6'h12;
    localparam logic [5:0] IDX_REVISION  = 6'h13;
    localparam logic [5:0] IDX_THR_FIRST = 6'h14;
    localparam logic [5:0] IDX_THR_LAST  = 6'h25;
    localparam logic [5:0] IDX_ACQ_TIME  = 6'h26;

    // ----------------------------------------
    // mode and status fields
    // ----------------------------------------
    localparam int MODE_PRI_BIT = 8;
    localparam int MODE_SEC_BIT = 9;
    localparam int MODE_HV0_BIT = 1;
    localparam int MODE_HV1_BIT = 2;
    localparam int STAT_REJ_BIT = 0;
    localparam int STAT_HV0_BIT = 1;
    localparam int STAT_HV1_BIT = 2;
    localparam int STAT_PRI_BIT = 3;
    localparam int STAT_SEC_BIT = 4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [4:0] RST_REJ_DLY = 5'h05;
    localparam logic [11:0] RST_BIAS_LVL = 12'h000;
    localparam logic [11:0] RST_ANOM_LVL = 12'h000;
    localparam logic [6:0] RST_SHAPER = 7'h1C;
    localparam logic [2:0] RST_REJ_WID = 3'h2;
    localparam logic [3:0] RST_HIT_WID = 4'h7;
    localparam logic [2:0] RST_HIT_DEAD = 3'h3;
    localparam logic [4:0] RST_HIT_DLY = 5'h10;
    localparam logic [15:0] RST_PH_EN_LO = 16'hFFFF;
    localparam logic [1:0] RST_PH_EN_HI = 2'h3;
    localparam logic [15:0] RST_REJ_EN_LO = 16'hFFFF;
    localparam logic [1:0] RST_REJ_EN_HI = 2'h3;
    localparam logic [4:0] RST_PH_MAX = 5'h04;
    localparam logic [10:0] RST_MODE = 11'h300;
    localparam logic [15:0] RST_THR = 16'h045A;
    localparam logic [5:0] RST_ACQ_TIME = 6'h00;

    typedef struct packed {
        logic [4:0] rej_dly;
        logic [11:0] bias_lvl;
        logic [11:0] anom_lvl;
        logic [6:0] shaper;
        logic [2:0] rej_wid;
        logic [3:0] hit_wid;
        logic [2:0] hit_dead;
        logic [4:0] hit_dly;
        logic [15:0] ph_en_lo;
        logic [1:0] ph_en_hi;
        logic [15:0] rej_en_lo;
        logic [1:0] rej_en_hi;
        logic [4:0] ph_max;
        logic [10:0] mode;
        logic [5:0] acq_time;
        logic [15:0] last_cmd;
        logic [15:0] diag;
        logic [7:0] rej_cnt;
        logic [7:0] board_id;
        logic last_rej;
        logic rsp_v;
        logic rsp_err;
        logic [15:0] rsp_d;
    } rcrb_state_t;

    function automatic rcrb_state_t rcrb_init();
        rcrb_state_t s;
        s = '0;
        s.rej_dly = RST_REJ_DLY;
        s.bias_lvl = RST_BIAS_LVL;
        s.anom_lvl = RST_ANOM_LVL;
        s.shaper = RST_SHAPER;
        s.rej_wid = RST_REJ_WID;
        s.hit_wid = RST_HIT_WID;
        s.hit_dead = RST_HIT_DEAD;
        s.hit_dly = RST_HIT_DLY;
        s.ph_en_lo = RST_PH_EN_LO;
        s.ph_en_hi = RST_PH_EN_HI;
        s.rej_en_lo = RST_REJ_EN_LO;
        s.rej_en_hi = RST_REJ_EN_HI;
        s.ph_max = RST_PH_MAX;
        s.mode = RST_MODE;
        s.acq_time = RST_ACQ_TIME;
        return s;
    endfunction : rcrb_init

endpackage : rcrb_pkg

// ==== rcrb_register_bank.sv ====
`timescale 1ns/1ps
module rcrb_register_bank #(
    parameter logic [2:0] REVISION = 3'h1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_op_in,
    input wire logic [5:0] cmd_addr_in,
    input wire logic [15:0] cmd_data_in,
    input wire logic [7:0] board_id_in,
    output logic rsp_valid_out,
    output logic [15:0] rsp_data_out,
    output logic rsp_error_out,
    output logic primary_drv_en_out,
    output logic secondary_drv_en_out,
    output logic [1:0] bias_supply_en_out,
    output logic [11:0] bias_supply_level_out,
    output logic [4:0] reject_pulse_delay_out
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic is_thr(input logic [5:0] a);
        return (a >= rcrb_pkg::IDX_THR_FIRST) && (a <= rcrb_pkg::IDX_THR_LAST);
    endfunction : is_thr

    function automatic logic is_ro(input logic [5:0] a);
        return (a >= rcrb_pkg::IDX_STATUS) && (a <= rcrb_pkg::IDX_REVISION);
    endfunction : is_ro

    function automatic logic is_mapped(input logic [5:0] a);
        return (a <= rcrb_pkg::IDX_ACQ_TIME);
    endfunction : is_mapped

    rcrb_pkg::rcrb_state_t r_q;
    rcrb_pkg::rcrb_state_t r_d;
    logic [15:0] thr_rd;
    logic [4:0] thr_idx;
    logic thr_wr;
    logic thr_clr;
    logic [5:0] status;
    logic is_wr;
    logic is_rd;
    logic is_rst;

    assign is_rd = cmd_valid_in && (cmd_op_in == rcrb_pkg::RCRB_OP_READ);
    assign is_wr = cmd_valid_in && (cmd_op_in == rcrb_pkg::RCRB_OP_WRITE);
    assign is_rst = cmd_valid_in && (cmd_op_in == rcrb_pkg::RCRB_OP_RESET);
    assign thr_idx = 5'(cmd_addr_in - rcrb_pkg::IDX_THR_FIRST);
    assign thr_wr = is_wr && is_thr(cmd_addr_in);
    assign thr_clr = is_rst;

    // ----------------------------------------
    // threshold storage
    // ----------------------------------------
    rcrb_threshold_bank #(
        .NUM_CH(rcrb_pkg::NUM_CH),
        .DATA_W(rcrb_pkg::DATA_W),
        .RST_VAL(rcrb_pkg::RST_THR)
    ) u_thr (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(thr_clr),
        .wr_en_in(thr_wr),
        .idx_in(thr_idx),
        .wr_data_in(cmd_data_in),
        .rd_data_out(thr_rd)
    );

    // ----------------------------------------
    // status word
    // ----------------------------------------
    // at power-on the mode enables both driver sets, so status reads 24
    always_comb
    begin
        status = '0;
        status[rcrb_pkg::STAT_REJ_BIT] = r_q.last_rej;
        status[rcrb_pkg::STAT_HV0_BIT] = r_q.mode[rcrb_pkg::MODE_HV0_BIT];
        status[rcrb_pkg::STAT_HV1_BIT] = r_q.mode[rcrb_pkg::MODE_HV1_BIT];
        status[rcrb_pkg::STAT_PRI_BIT] = r_q.mode[rcrb_pkg::MODE_PRI_BIT];
        status[rcrb_pkg::STAT_SEC_BIT] = r_q.mode[rcrb_pkg::MODE_SEC_BIT];
    end

    // ----------------------------------------
    // command handling
    // ----------------------------------------
    always_comb
    begin
        r_d = r_q;
        r_d.rsp_v = 1'b0;
        r_d.board_id = board_id_in;
        if (cmd_valid_in)
        begin
            r_d.rsp_v = 1'b1;
            r_d.rsp_err = 1'b0;
            r_d.rsp_d = '0;
            r_d.last_rej = 1'b0;
            r_d.last_cmd = {cmd_op_in, cmd_addr_in, cmd_data_in[7:0]};
            unique case (cmd_op_in)
                rcrb_pkg::RCRB_OP_RESET:
                begin
                    r_d = rcrb_pkg::rcrb_init();
                    r_d.board_id = board_id_in;
                    r_d.rsp_v = 1'b1;
                end
                rcrb_pkg::RCRB_OP_READ:
                begin
                    unique case (cmd_addr_in)
                        rcrb_pkg::IDX_REJ_DLY: r_d.rsp_d = 16'(r_q.rej_dly);
                        rcrb_pkg::IDX_BIAS_LVL: r_d.rsp_d = 16'(r_q.bias_lvl);
                        rcrb_pkg::IDX_ANOM_LVL: r_d.rsp_d = 16'(r_q.anom_lvl);
                        rcrb_pkg::IDX_SHAPER: r_d.rsp_d = 16'(r_q.shaper);
                        rcrb_pkg::IDX_REJ_WID: r_d.rsp_d = 16'(r_q.rej_wid);
                        rcrb_pkg::IDX_HIT_WID: r_d.rsp_d = 16'(r_q.hit_wid);
                        rcrb_pkg::IDX_HIT_DEAD: r_d.rsp_d = 16'(r_q.hit_dead);
                        rcrb_pkg::IDX_HIT_DLY: r_d.rsp_d = 16'(r_q.hit_dly);
                        rcrb_pkg::IDX_PH_EN_LO: r_d.rsp_d = r_q.ph_en_lo;
                        rcrb_pkg::IDX_PH_EN_HI: r_d.rsp_d = 16'(r_q.ph_en_hi);
                        rcrb_pkg::IDX_REJ_EN_LO: r_d.rsp_d = r_q.rej_en_lo;
                        rcrb_pkg::IDX_REJ_EN_HI: r_d.rsp_d = 16'(r_q.rej_en_hi);
                        rcrb_pkg::IDX_PH_MAX: r_d.rsp_d = 16'(r_q.ph_max);
                        rcrb_pkg::IDX_MODE: r_d.rsp_d = 16'(r_q.mode);
                        rcrb_pkg::IDX_STATUS: r_d.rsp_d = 16'(status);
                        rcrb_pkg::IDX_LAST_CMD: r_d.rsp_d = r_q.last_cmd;
                        rcrb_pkg::IDX_DIAG: r_d.rsp_d = r_q.diag;
                        rcrb_pkg::IDX_REJ_CNT: r_d.rsp_d = 16'(r_q.rej_cnt);
                        rcrb_pkg::IDX_BOARD_ID: r_d.rsp_d = 16'(r_q.board_id);
                        rcrb_pkg::IDX_REVISION: r_d.rsp_d = 16'(REVISION);
                        rcrb_pkg::IDX_ACQ_TIME: r_d.rsp_d = 16'(r_q.acq_time);
                        default:
                        begin
                            if (is_thr(cmd_addr_in))
                            begin
                                r_d.rsp_d = thr_rd;
                            end
                            else
                            begin
                                r_d.rsp_err = 1'b1;
                                r_d.last_rej = 1'b1;
                                r_d.rej_cnt = 8'(r_q.rej_cnt + 8'h01);
                            end
                        end
                    endcase
                end
                rcrb_pkg::RCRB_OP_WRITE:
                begin
                    // rejected writes leave the diagnostic count untouched
                    if (is_ro(cmd_addr_in) || !is_mapped(cmd_addr_in))
                    begin
                        r_d.rsp_err = 1'b1;
                        r_d.last_rej = 1'b1;
                        r_d.rej_cnt = 8'(r_q.rej_cnt + 8'h01);
                    end
                    else
                    begin
                        r_d.diag = 16'(r_q.diag + 16'h0001);
                    end
                    unique case (cmd_addr_in)
                        rcrb_pkg::IDX_REJ_DLY: r_d.rej_dly = cmd_data_in[4:0];
                        rcrb_pkg::IDX_BIAS_LVL: r_d.bias_lvl = cmd_data_in[11:0];
                        rcrb_pkg::IDX_ANOM_LVL: r_d.anom_lvl = cmd_data_in[11:0];
                        rcrb_pkg::IDX_SHAPER: r_d.shaper = cmd_data_in[6:0];
                        rcrb_pkg::IDX_REJ_WID: r_d.rej_wid = cmd_data_in[2:0];
                        rcrb_pkg::IDX_HIT_WID: r_d.hit_wid = cmd_data_in[3:0];
                        rcrb_pkg::IDX_HIT_DEAD: r_d.hit_dead = cmd_data_in[2:0];
                        rcrb_pkg::IDX_HIT_DLY: r_d.hit_dly = cmd_data_in[4:0];
                        rcrb_pkg::IDX_PH_EN_LO: r_d.ph_en_lo = cmd_data_in;
                        rcrb_pkg::IDX_PH_EN_HI: r_d.ph_en_hi = cmd_data_in[1:0];
                        rcrb_pkg::IDX_REJ_EN_LO: r_d.rej_en_lo = cmd_data_in;
                        rcrb_pkg::IDX_REJ_EN_HI: r_d.rej_en_hi = cmd_data_in[1:0];
                        rcrb_pkg::IDX_PH_MAX: r_d.ph_max = cmd_data_in[4:0];
                        rcrb_pkg::IDX_MODE: r_d.mode = cmd_data_in[10:0];
                        rcrb_pkg::IDX_ACQ_TIME: r_d.acq_time = cmd_data_in[5:0];
                        default:
                        begin
                        end
                    endcase
                end
                default:
                begin
                    r_d.rsp_err = 1'b1;
                    r_d.last_rej = 1'b1;
                    r_d.rej_cnt = 8'(r_q.rej_cnt + 8'h01);
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            r_q <= rcrb_pkg::rcrb_init();
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rsp_valid_out = r_q.rsp_v;
    assign rsp_data_out = r_q.rsp_d;
    assign rsp_error_out = r_q.rsp_err;
    assign primary_drv_en_out = r_q.mode[rcrb_pkg::MODE_PRI_BIT];
    assign secondary_drv_en_out = r_q.mode[rcrb_pkg::MODE_SEC_BIT];
    assign bias_supply_en_out = {r_q.mode[rcrb_pkg::MODE_HV1_BIT], r_q.mode[rcrb_pkg::MODE_HV0_BIT]};
    assign bias_supply_level_out = r_q.bias_lvl;
    assign reject_pulse_delay_out = r_q.rej_dly;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    logic mode_wr;
    assign mode_wr = is_wr && (cmd_addr_in == rcrb_pkg::IDX_MODE);

    property p_both_drv;
        @(posedge clk_in) disable iff (rst_in)
        mode_wr && (cmd_data_in == 16'h0300) |=> primary_drv_en_out && secondary_drv_en_out;
    endproperty
    a_both_drv: assert property (p_both_drv) else $error("768 did not enable both drivers");

    property p_pri_only;
        @(posedge clk_in) disable iff (rst_in)
        mode_wr && (cmd_data_in == 16'h0100) |=> primary_drv_en_out && !secondary_drv_en_out;
    endproperty
    a_pri_only: assert property (p_pri_only) else $error("256 did not select primary only");

    property p_sec_only;
        @(posedge clk_in) disable iff (rst_in)
        mode_wr && (cmd_data_in == 16'h0200) |=> !primary_drv_en_out && secondary_drv_en_out;
    endproperty
    a_sec_only: assert property (p_sec_only) else $error("512 did not select secondary only");

    property p_no_drv;
        @(posedge clk_in) disable iff (rst_in)
        mode_wr && (cmd_data_in == 16'h0000) |=> !primary_drv_en_out && !secondary_drv_en_out;
    endproperty
    a_no_drv: assert property (p_no_drv) else $error("0 did not disable drivers");

    property p_mode_rb;
        @(posedge clk_in) disable iff (rst_in)
        mode_wr ##1 (is_rd && cmd_addr_in == rcrb_pkg::IDX_MODE)
        |=> rsp_valid_out && (rsp_data_out == {5'h00, $past(cmd_data_in[10:0], 2)});
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback mismatch");

    property p_hv_en;
        @(posedge clk_in) disable iff (rst_in)
        mode_wr && (cmd_data_in == 16'h037E)
        |=> (bias_supply_en_out == 2'h3) && primary_drv_en_out && secondary_drv_en_out;
    endproperty
    a_hv_en: assert property (p_hv_en) else $error("894 did not enable bias supplies");

    property p_rst_cmd;
        @(posedge clk_in) disable iff (rst_in)
        is_rst |=> (reject_pulse_delay_out == 5'h05) && (bias_supply_level_out == 12'h000)
            && primary_drv_en_out && secondary_drv_en_out && (bias_supply_en_out == 2'h0);
    endproperty
    a_rst_cmd: assert property (p_rst_cmd) else $error("reset command left stale values");

    property p_dly_rb;
        @(posedge clk_in) disable iff (rst_in)
        is_wr && (cmd_addr_in == rcrb_pkg::IDX_REJ_DLY) |=> reject_pulse_delay_out == $past(cmd_data_in[4:0]);
    endproperty
    a_dly_rb: assert property (p_dly_rb) else $error("reject delay did not store five bits");

    property p_ro_ignored;
        @(posedge clk_in) disable iff (rst_in)
        is_wr && is_ro(cmd_addr_in) |=> rsp_error_out && $stable(r_q.diag) && $stable(r_q.mode);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write took effect");

    property p_answer;
        @(posedge clk_in) disable iff (rst_in)
        cmd_valid_in |=> rsp_valid_out ##1 (rsp_valid_out == $past(cmd_valid_in));
    endproperty
    a_answer: assert property (p_answer) else $error("command not answered once");

    property p_por_level;
        @(posedge clk_in)
        $fell(rst_in)
        |-> (bias_supply_level_out == 12'h000);
    endproperty
    a_por_level: assert property (p_por_level) else $error("bias level not zero after reset");

    property p_por_mode;
        @(posedge clk_in)
        $fell(rst_in)
        |-> primary_drv_en_out && secondary_drv_en_out && (reject_pulse_delay_out == 5'h05);
    endproperty
    a_por_mode: assert property (p_por_mode) else $error("power-on mode or delay wrong");

    property p_bias_wr;
        @(posedge clk_in) disable iff (rst_in)
        is_wr && (cmd_addr_in == rcrb_pkg::IDX_BIAS_LVL)
        |=> bias_supply_level_out == $past(cmd_data_in[11:0]);
    endproperty
    a_bias_wr: assert property (p_bias_wr) else $error("bias level bits not stored");

    property p_mode_bits;
        @(posedge clk_in) disable iff (rst_in)
        is_rd && (cmd_addr_in == rcrb_pkg::IDX_MODE)
        |=> rsp_data_out[9:8] == {secondary_drv_en_out, primary_drv_en_out};
    endproperty
    a_mode_bits: assert property (p_mode_bits) else $error("mode bits 8 and 9 differ from drivers");

    property p_ro_count;
        @(posedge clk_in) disable iff (rst_in)
        is_wr && is_ro(cmd_addr_in)
        |=> r_q.rej_cnt == 8'($past(r_q.rej_cnt) + 8'h01);
    endproperty
    a_ro_count: assert property (p_ro_count) else $error("refused write not counted");

    // ----------------------------------------
    // coverage
    // ----------------------------------------
    c_mode_rb: cover property (@(posedge clk_in) disable iff (rst_in) mode_wr ##1 is_rd);
    c_rst_cmd: cover property (@(posedge clk_in) disable iff (rst_in) is_rst);
    c_thr_rb: cover property (@(posedge clk_in) disable iff (rst_in) thr_wr ##1 (is_rd && is_thr(cmd_addr_in)));
    c_hv_mode: cover property (@(posedge clk_in) disable iff (rst_in) mode_wr && (cmd_data_in == 16'h037E));
    c_refused: cover property (@(posedge clk_in) disable iff (rst_in) rsp_valid_out && rsp_error_out);

endmodule : rcrb_register_bank

// ==== rcrb_threshold_bank.sv ====
`timescale 1ns/1ps
module rcrb_threshold_bank #(
    parameter int NUM_CH = 18,
    parameter int DATA_W = 16,
    parameter logic [15:0] RST_VAL = 16'h045A
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    input wire logic wr_en_in,
    input wire logic [4:0] idx_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    output logic [DATA_W-1:0] rd_data_out
);

    typedef struct packed {
        logic [NUM_CH-1:0][DATA_W-1:0] thr;
    } rcrb_thr_state_t;

    rcrb_thr_state_t r_q;
    rcrb_thr_state_t r_d;

    // out-of-range index reads zero rather than aliasing a channel
    assign rd_data_out = (int'(idx_in) < NUM_CH) ? r_q.thr[idx_in] : '0;

    always_comb
    begin
        r_d = r_q;
        if (clear_in)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                r_d.thr[i] = RST_VAL[DATA_W-1:0];
            end
        end
        else if (wr_en_in && (int'(idx_in) < NUM_CH))
        begin
            r_d.thr[idx_in] = wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                r_q.thr[i] <= RST_VAL[DATA_W-1:0];
            end
        end
        else
        begin
            r_q <= r_d;
        end
    end

endmodule : rcrb_threshold_bank

// ==== tb_rcrb_register_bank.sv ====
`timescale 1ns/1ps
module tb_rcrb_register_bank;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid;
    logic [1:0] cmd_op;
    logic [5:0] cmd_addr;
    logic [15:0] cmd_data;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic rsp_error;
    logic pri_en;
    logic sec_en;
    logic [1:0] bias_en;
    logic [11:0] bias_lvl;
    logic [4:0] rej_dly;
    int mismatches = 0;
    int num_checks = 0;

    always #5 clk_in = ~clk_in;

    rcrb_register_bank dut_u (.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
        .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .board_id_in(8'hA5), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .rsp_error_out(rsp_error), .primary_drv_en_out(pri_en),
        .secondary_drv_en_out(sec_en), .bias_supply_en_out(bias_en), .bias_supply_level_out(bias_lvl),
        .reject_pulse_delay_out(rej_dly));

    rcrb_host_model host_u (.clk_in(clk_in), .rsp_valid_in(rsp_valid), .rsp_data_in(rsp_data),
        .rsp_error_in(rsp_error), .cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op), .cmd_addr_out(cmd_addr),
        .cmd_data_out(cmd_data));

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
                       output logic [15:0] rd, output logic err);
        bit ok;
        host_u.send(op, a, d, rd, err, ok);
        if (!ok)
        begin
            mismatches++;
            $display("CHECK FAILED response expected 1 seen 0");
            complete_run();
        end
    endtask : cmd

    task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] rd;
        logic err;
        cmd(rcrb_pkg::RCRB_OP_READ, a, 16'h0000, rd, err);
        check(what, exp, rd);
    endtask : rd_chk

    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic exp_err);
        logic [15:0] rd;
        logic err;
        cmd(rcrb_pkg::RCRB_OP_WRITE, a, d, rd, err);
        check("write error flag", {15'h0000, exp_err}, {15'h0000, err});
    endtask : wr

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_power_on();
        rd_chk("mode", rcrb_pkg::IDX_MODE, 16'h0300);
        rd_chk("delay", rcrb_pkg::IDX_REJ_DLY, 16'h0005);
        rd_chk("bias level", rcrb_pkg::IDX_BIAS_LVL, 16'h0000);
        check("driver enables", 16'h0003, {14'h0000, sec_en, pri_en});
        $display("test power_on done");
    endtask : test_power_on

    task automatic test_mode_sweep();
        logic [15:0] tbl [5] = '{16'h0300, 16'h0100, 16'h0200, 16'h0000, 16'h037E};
        for (int i = 0; i < 5; i++)
        begin
            wr(rcrb_pkg::IDX_MODE, tbl[i], 1'b0);
            rd_chk("mode readback", rcrb_pkg::IDX_MODE, tbl[i]);
            check("driver enables", {14'h0000, tbl[i][9:8]}, {14'h0000, sec_en, pri_en});
            check("bias enables", {14'h0000, tbl[i][2:1]}, {14'h0000, bias_en});
        end
        $display("test mode_sweep done");
    endtask : test_mode_sweep

    task automatic test_patterns();
        logic [4:0] dly [5] = '{5'h00, 5'h15, 5'h0A, 5'h1F, 5'h05};
        logic [11:0] lvl [5] = '{12'h000, 12'h555, 12'hAAA, 12'hFFF, 12'h000};
        for (int i = 0; i < 5; i++)
        begin
            wr(rcrb_pkg::IDX_REJ_DLY, {11'h000, dly[i]}, 1'b0);
            rd_chk("delay readback", rcrb_pkg::IDX_REJ_DLY, {11'h000, dly[i]});
            check("delay output", {11'h000, dly[i]}, {11'h000, rej_dly});
            wr(rcrb_pkg::IDX_BIAS_LVL, {4'h0, lvl[i]}, 1'b0);
            rd_chk("bias readback", rcrb_pkg::IDX_BIAS_LVL, {4'h0, lvl[i]});
            check("bias output", {4'h0, lvl[i]}, {4'h0, bias_lvl});
        end
        $display("test patterns done");
    endtask : test_patterns

    // a refused write must leave read-only contents alone
    task automatic test_read_only();
        wr(rcrb_pkg::IDX_STATUS, 16'hFFFF, 1'b1);
        wr(rcrb_pkg::IDX_REVISION, 16'h0007, 1'b1);
        rd_chk("revision", rcrb_pkg::IDX_REVISION, 16'h0001);
        rd_chk("reject count", rcrb_pkg::IDX_REJ_CNT, 16'h0002);
        $display("test read_only done");
    endtask : test_read_only

    task automatic test_reset_cmd();
        logic [15:0] rd;
        logic err;
        wr(rcrb_pkg::IDX_REJ_DLY, 16'h001F, 1'b0);
        wr(rcrb_pkg::IDX_MODE, 16'h0000, 1'b0);
        wr(rcrb_pkg::IDX_THR_FIRST, 16'h1234, 1'b0);
        cmd(rcrb_pkg::RCRB_OP_RESET, 6'h00, 16'h0000, rd, err);
        rd_chk("delay after reset", rcrb_pkg::IDX_REJ_DLY, 16'h0005);
        rd_chk("mode after reset", rcrb_pkg::IDX_MODE, 16'h0300);
        rd_chk("threshold after reset", rcrb_pkg::IDX_THR_LAST, 16'h045A);
        rd_chk("reject count after reset", rcrb_pkg::IDX_REJ_CNT, 16'h0000);
        check("driver enables", 16'h0003, {14'h0000, sec_en, pri_en});
        $display("test reset_cmd done");
    endtask : test_reset_cmd

    // a read on the edge right after a write already sees the new value
    task automatic test_back_to_back();
        logic [15:0] rd;
        logic err;
        host_u.lead_write = 1'b1;
        cmd(rcrb_pkg::RCRB_OP_READ, rcrb_pkg::IDX_MODE, 16'h0100, rd, err);
        check("mode behind write", 16'h0100, rd);
        cmd(rcrb_pkg::RCRB_OP_READ, rcrb_pkg::IDX_THR_LAST, 16'hA5C3, rd, err);
        check("threshold behind write", 16'hA5C3, rd);
        host_u.lead_write = 1'b0;
        $display("test back_to_back done");
    endtask : test_back_to_back

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        test_power_on();
        test_mode_sweep();
        test_back_to_back();
        test_patterns();
        test_read_only();
        test_reset_cmd();
        complete_run();
    end
endmodule : tb_rcrb_register_bank
